//--- hw/csf_regs.vh
`ifndef CSF_REGS_VH
`define CSF_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CSF_ADDR_MISC       8'h07
`define CSF_ADDR_STATUS     8'h08
`define CSF_ADDR_FAULT      8'h09

// ----------------------------------------
// Control register fields and reset
// ----------------------------------------
`define CSF_MISC_RESET      8'h4B
`define CSF_B_DETECT        7
`define CSF_B_HALF_RATE     6
`define CSF_B_SW_OFF        5
`define CSF_B_CHG_IEN       1
`define CSF_B_BAT_IEN       0

// ----------------------------------------
// Status encodings
// ----------------------------------------
`define CSF_SRC_UNKNOWN     2'h0
`define CSF_SRC_USB_HOST    2'h1
`define CSF_SRC_ADAPTER     2'h2
`define CSF_SRC_BOOST       2'h3
`define CSF_PH_IDLE         2'h0
`define CSF_PH_PRE          2'h1
`define CSF_PH_FAST         2'h2
`define CSF_PH_DONE         2'h3

// ----------------------------------------
// Fault encodings and fields
// ----------------------------------------
`define CSF_CF_NORMAL       2'h0
`define CSF_CF_INPUT        2'h1
`define CSF_CF_THERMAL      2'h2
`define CSF_CF_TIMER        2'h3
`define CSF_B_WDOG          7
`define CSF_B_BOOST         6
`define CSF_B_BATOV         3
`define CSF_B_COLD          1
`define CSF_B_HOT           0

`endif

//--- hw/csf_timer_tick.v
`timescale 1ns/1ps
`default_nettype none
// Safety timer advance pulse, halved while limiting or thermal regulating if enabled
module csf_timer_tick (
  input  wire core_clk_i,
  input  wire rst_n_i,
  input  wire base_tick_i,
  input  wire half_rate_en_i,
  input  wire slow_cond_i,
  output reg  timer_tick_o
);
  reg skip_r;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      skip_r       <= 1'b0;
      timer_tick_o <= 1'b0;
    end else begin
      timer_tick_o <= 1'b0;
      if (base_tick_i) begin
        if (half_rate_en_i && slow_cond_i) begin
          skip_r       <= ~skip_r;
          timer_tick_o <= skip_r;
        end else begin
          skip_r       <= 1'b0;
          timer_tick_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/csf_sync2.v
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a bus of levels
module csf_sync2 #(
  parameter W = 8
) (
  input  wire         core_clk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);
  reg [W-1:0] meta_r;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- hw/csf_regbank.v
// Contract
// - Force detect bit self-clears after detection
// - Half-rate safety timer during limiting or thermal regulation if set
// - Force-off bit turns battery switch off
// - Charge fault interrupt enable, resets one
// - Battery fault interrupt enable, resets one
// - Input source type two-bit status
// - Charge phase two-bit status
// - Limiting, power good, thermal status bits
// - Minimum system voltage regulation status bit
// - Watchdog fault latched until read
// - Boost fault on any boost-blocking condition
// - Charge fault code encoding
// - Battery overvoltage fault bit
// - Cold and hot thermistor fault bits
// - Faults latch; read returns then clears
// - After clearing read reload persisting faults
// - Adapter removal sets input code once
`timescale 1ns/1ps
`default_nettype none
`include "csf_regs.vh"

module csf_regbank (
  input  wire       core_clk_i,
  input  wire       rst_n_i,
  // Register access from the serial slave, same clock
  input  wire [7:0] reg_addr_i,
  input  wire       reg_wr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  // Analog and power-stage conditions (asynchronous)
  input  wire       input_present_i,
  input  wire       detect_done_i,
  input  wire [1:0] input_source_type_i,
  input  wire [1:0] charge_phase_i,
  input  wire       input_voltage_limiting_i,
  input  wire       input_current_limiting_i,
  input  wire       input_power_good_i,
  input  wire       thermal_regulating_i,
  input  wire       min_system_regulating_i,
  input  wire       boost_mode_i,
  input  wire       watchdog_expired_i,
  input  wire       boost_overload_i,
  input  wire       input_overvoltage_i,
  input  wire       battery_too_low_i,
  input  wire       bad_source_i,
  input  wire       thermal_shutdown_i,
  input  wire       safety_timer_expired_i,
  input  wire       battery_overvoltage_i,
  input  wire       cold_buck_i,
  input  wire       hot_buck_i,
  input  wire       cold_boost_i,
  input  wire       hot_boost_i,
  // Same-clock timebase for the safety timer
  input  wire       timer_base_tick_i,
  // Controls and interrupt
  output reg        force_line_detect_o,
  output reg        timer_half_rate_en_o,
  output reg        battery_switch_force_off_o,
  output reg        timer_tick_o,
  output reg        irq_o
);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  localparam NS = 25;
  wire [NS-1:0] raw_w;
  wire [NS-1:0] syn_w;

  assign raw_w = {input_present_i, detect_done_i, input_source_type_i,
                  charge_phase_i, input_voltage_limiting_i,
                  input_current_limiting_i, input_power_good_i,
                  thermal_regulating_i, min_system_regulating_i,
                  boost_mode_i, watchdog_expired_i, boost_overload_i,
                  input_overvoltage_i, battery_too_low_i, bad_source_i,
                  thermal_shutdown_i, safety_timer_expired_i,
                  battery_overvoltage_i, cold_buck_i, hot_buck_i,
                  cold_boost_i, hot_boost_i, 1'b0};

  csf_sync2 #(.W(NS)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    (raw_w),
    .sync_o     (syn_w)
  );

  wire       s_present   = syn_w[24];
  wire       s_done      = syn_w[23];
  wire [1:0] s_src       = syn_w[22:21];
  wire [1:0] s_phase     = syn_w[20:19];
  wire       s_vlim      = syn_w[18];
  wire       s_ilim      = syn_w[17];
  wire       s_pg        = syn_w[16];
  wire       s_therm     = syn_w[15];
  wire       s_minsys    = syn_w[14];
  wire       s_boost     = syn_w[13];
  wire       s_wdog      = syn_w[12];
  wire       s_bovl      = syn_w[11];
  wire       s_ovp       = syn_w[10];
  wire       s_blow      = syn_w[9];
  wire       s_bad       = syn_w[8];
  wire       s_tsd       = syn_w[7];
  wire       s_tmr       = syn_w[6];
  wire       s_batov     = syn_w[5];
  wire       s_cold_bk   = syn_w[4];
  wire       s_hot_bk    = syn_w[3];
  wire       s_cold_bst  = syn_w[2];
  wire       s_hot_bst   = syn_w[1];
  wire       s_unused    = syn_w[0];

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  reg  [7:0] misc_r;
  wire       wr_misc = reg_wr_i && (reg_addr_i == `CSF_ADDR_MISC);
  reg        present_d_r;
  reg        adapter_d_r;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      misc_r <= `CSF_MISC_RESET;
    end else begin
      if (wr_misc) begin
        misc_r <= reg_wdata_i;
      end
      if (s_done && misc_r[`CSF_B_DETECT] && !(wr_misc && reg_wdata_i[`CSF_B_DETECT])) begin
        misc_r[`CSF_B_DETECT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Status composition
  // ----------------------------------------
  wire [7:0] status_w;
  assign status_w = {s_src, s_phase, (s_vlim | s_ilim), s_pg, s_therm, s_minsys};

  // ----------------------------------------
  // Live fault conditions
  // ----------------------------------------
  wire       adapter_gone = present_d_r && !s_present && adapter_d_r;
  reg  [1:0] cf_live;
  always @* begin
    cf_live = `CSF_CF_NORMAL;
    if (s_ovp || s_bad) begin
      cf_live = `CSF_CF_INPUT;
    end
    if (s_tsd) begin
      cf_live = `CSF_CF_THERMAL;
    end
    if (s_tmr) begin
      cf_live = `CSF_CF_TIMER;
    end
  end

  wire cold_w = s_boost ? s_cold_bst : s_cold_bk;
  wire hot_w  = s_boost ? s_hot_bst  : s_hot_bk;
  wire [7:0] live_w;
  assign live_w = {s_wdog, (s_bovl | s_ovp | s_blow), cf_live, s_batov, 1'b0, cold_w, hot_w};

  // ----------------------------------------
  // Latched fault register
  // ----------------------------------------
  reg  [7:0] fault_r;
  reg  [7:0] fault_nxt;
  reg  [7:0] new_bits;
  wire       rd_fault = reg_rd_i && (reg_addr_i == `CSF_ADDR_FAULT);
  reg  [1:0] cf_evt;

  always @* begin
    cf_evt = cf_live;
    if (adapter_gone && (cf_live == `CSF_CF_NORMAL)) begin
      cf_evt = `CSF_CF_INPUT;
    end
    if (rd_fault) begin
      fault_nxt = {live_w[7:6], cf_evt, live_w[3:0]};
    end else begin
      fault_nxt = fault_r | {live_w[7:6], 2'h0, live_w[3:0]};
      if (fault_r[5:4] == `CSF_CF_NORMAL) begin
        fault_nxt[5:4] = cf_evt;
      end
    end
    fault_nxt[2] = 1'b0;
    new_bits = fault_nxt & ~fault_r;
    if (fault_nxt[5:4] != fault_r[5:4]) begin
      new_bits[5:4] = 2'h3;
    end else begin
      new_bits[5:4] = 2'h0;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_r     <= 8'h00;
      present_d_r <= 1'b0;
      adapter_d_r <= 1'b0;
    end else begin
      fault_r     <= fault_nxt;
      present_d_r <= s_present;
      adapter_d_r <= (s_src == `CSF_SRC_ADAPTER);
    end
  end

  // ----------------------------------------
  // Interrupt and outputs
  // ----------------------------------------
  wire irq_evt;
  assign irq_evt = new_bits[`CSF_B_WDOG] | new_bits[`CSF_B_BOOST]
                 | new_bits[`CSF_B_COLD] | new_bits[`CSF_B_HOT]
                 | (misc_r[`CSF_B_CHG_IEN] & (new_bits[5] | new_bits[4]) & (fault_nxt[5:4] != `CSF_CF_NORMAL))
                 | (misc_r[`CSF_B_BAT_IEN] & new_bits[`CSF_B_BATOV]);

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o                <= 8'h00;
      force_line_detect_o        <= 1'b0;
      timer_half_rate_en_o       <= 1'b1;
      battery_switch_force_off_o <= 1'b0;
      irq_o                      <= 1'b0;
    end else begin
      // Detect request only meaningful with input present
      force_line_detect_o        <= misc_r[`CSF_B_DETECT] & s_present;
      timer_half_rate_en_o       <= misc_r[`CSF_B_HALF_RATE];
      battery_switch_force_off_o <= misc_r[`CSF_B_SW_OFF];
      irq_o                      <= irq_evt;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `CSF_ADDR_MISC:   reg_rdata_o <= misc_r;
          `CSF_ADDR_STATUS: reg_rdata_o <= status_w;
          `CSF_ADDR_FAULT:  reg_rdata_o <= fault_r;
          default:          reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Safety timer pacing
  // ----------------------------------------
  wire tick_w;
  csf_timer_tick u_tick (
    .core_clk_i     (core_clk_i),
    .rst_n_i        (rst_n_i),
    .base_tick_i    (timer_base_tick_i),
    .half_rate_en_i (misc_r[`CSF_B_HALF_RATE]),
    .slow_cond_i    (s_vlim | s_ilim | s_therm),
    .timer_tick_o   (tick_w)
  );

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_tick_o <= 1'b0;
    end else begin
      timer_tick_o <= tick_w & ~s_unused;
    end
  end

endmodule
`default_nettype wire

//--- tb/csf_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port-level checks of the register bank
// ----------------------------------------
module csf_checker (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       input_present_i,
  input wire logic       detect_done_i,
  input wire logic       watchdog_expired_i,
  input wire logic       timer_base_tick_i,
  input wire logic       force_line_detect_o,
  input wire logic       timer_half_rate_en_o,
  input wire logic       battery_switch_force_off_o,
  input wire logic       timer_tick_o,
  input wire logic       irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_CTRL_WR: assert property (
    (reg_wr_i && reg_addr_i == 8'h07) ##1 (!reg_wr_i) [*3]
    |-> {timer_half_rate_en_o, battery_switch_force_off_o} == $past(reg_wdata_i[6:5], 3))
    else $error("control outputs do not follow the written byte");
  AST_UNMAPPED: assert property (
    reg_rd_i && (reg_addr_i < 8'h07 || reg_addr_i > 8'h09) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_RSVD_FLT: assert property (
    reg_rd_i && reg_addr_i == 8'h09 |=> reg_rdata_o[2] == 1'b0)
    else $error("reserved fault bit set");
  AST_RD_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  AST_IRQ_PULSE: assert property (irq_o |=> !irq_o)
    else $error("interrupt longer than one cycle");
  AST_WDOG_IRQ: assert property ($rose(watchdog_expired_i) |-> ##[2:6] irq_o)
    else $error("no interrupt after watchdog fault");
  AST_DETECT_GATE: assert property ((!input_present_i) [*4] |-> !force_line_detect_o)
    else $error("detection forced without input power");
  AST_DETECT_CLR: assert property (detect_done_i [*5] |-> !force_line_detect_o)
    else $error("detection request not cleared");
  AST_TICK: assert property (timer_tick_o |-> $past(timer_base_tick_i, 2))
    else $error("timer step without a base step");
  AST_TICK_FULL: assert property (
    timer_base_tick_i && !timer_half_rate_en_o |-> ##2 timer_tick_o)
    else $error("timer step dropped at full rate");
endmodule
bind csf_regbank csf_checker i_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .input_present_i(input_present_i), .detect_done_i(detect_done_i), .watchdog_expired_i(watchdog_expired_i),
  .timer_base_tick_i(timer_base_tick_i), .force_line_detect_o(force_line_detect_o),
  .timer_half_rate_en_o(timer_half_rate_en_o), .battery_switch_force_off_o(battery_switch_force_off_o),
  .timer_tick_o(timer_tick_o), .irq_o(irq_o));
`default_nettype wire

//--- tb/csf_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host side of the register access
// ----------------------------------------
module csf_host (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output var  logic [7:0] reg_addr_o,
  output var  logic       reg_wr_o,
  output var  logic [7:0] reg_wdata_o,
  output var  logic       reg_rd_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'h0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'h1;
    @(negedge core_clk_i);
    reg_wr_o = 1'h0;
    // Released data bus must not look valid
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'h1;
    @(negedge core_clk_i);
    reg_rd_o = 1'h0;
    d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk, rst_n, pres, done, wdog, bovl, blow, bsrc, tsd, tmo, bov, hbk, cbo, bmode;
  logic       vlim, ilim, pg, therm, vsys, btk, wr, rd, fld, half, off, tko, irq;
  logic [1:0] src, ph;
  logic [7:0] addr, wdata, rdata, d;
  int         n_mismatch, num_checks, n_irq, n_tick, cyc;
  csf_host i_host (.core_clk_i(clk), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rd_o(rd));
  csf_regbank i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .input_present_i(pres), .detect_done_i(done), .input_source_type_i(src),
    .charge_phase_i(ph), .input_voltage_limiting_i(vlim), .input_current_limiting_i(ilim),
    .input_power_good_i(pg), .thermal_regulating_i(therm), .min_system_regulating_i(vsys),
    .boost_mode_i(bmode), .watchdog_expired_i(wdog), .boost_overload_i(bovl), .input_overvoltage_i(1'h0),
    .battery_too_low_i(blow), .bad_source_i(bsrc), .thermal_shutdown_i(tsd), .safety_timer_expired_i(tmo),
    .battery_overvoltage_i(bov), .cold_buck_i(1'h0), .hot_buck_i(hbk), .cold_boost_i(cbo), .hot_boost_i(1'h0),
    .timer_base_tick_i(btk), .force_line_detect_o(fld), .timer_half_rate_en_o(half),
    .battery_switch_force_off_o(off), .timer_tick_o(tko), .irq_o(irq));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'h1) n_irq++;
    if (tko === 1'h1) n_tick++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk(d, e);
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rchk(8'h07, 8'h4B);
    chk({5'h00, fld, half, off}, 8'h02);
    i_host.wr(8'h08, 8'hFF);
    i_host.wr(8'h09, 8'hFF);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h00);
    rchk(8'h0A, 8'h00);
  endtask
  task automatic t_ctrl;
    i_host.wr(8'h07, 8'hA8);
    w(6);
    chk({5'h00, fld, half, off}, 8'h01);
    pres = 1'h1;
    w(6);
    chk({7'h00, fld}, 8'h01);
    done = 1'h1;
    w(6);
    chk({7'h00, fld}, 8'h00);
    rchk(8'h07, 8'h28);
    done = 1'h0;
    i_host.wr(8'h07, 8'h4B);
    w(4);
    chk({5'h00, fld, half, off}, 8'h02);
  endtask
  task automatic t_status;
    for (int i = 0; i < 4; i++) begin
      src = i[1:0];
      ph = ~i[1:0];
      vlim = (i == 1);
      ilim = (i == 2);
      {pg, therm, vsys} = {i[0], i[1], ~i[0]};
      w(4);
      rchk(8'h08, {src, ph, vlim | ilim, pg, therm, vsys});
    end
  endtask
  task automatic t_faults;
    {wdog, bovl, bov, hbk} = 4'hF;
    w(6);
    {wdog, bovl} = 2'h0;
    w(6);
    rchk(8'h09, 8'hC9);
    rchk(8'h09, 8'h09);
    {bov, hbk} = 2'h0;
    w(6);
    rchk(8'h09, 8'h09);
    rchk(8'h09, 8'h00);
    bmode = 1'h1;
    {cbo, hbk, blow} = 3'h7;
    w(6);
    {cbo, hbk, blow} = 3'h0;
    w(6);
    rchk(8'h09, 8'h42);
    rchk(8'h09, 8'h00);
    bmode = 1'h0;
    for (int k = 1; k < 4; k++) begin
      {tmo, tsd, bsrc} = 3'h1 << (k - 1);
      w(6);
      {tmo, tsd, bsrc} = 3'h0;
      w(6);
      rchk(8'h09, {2'h0, k[1:0], 4'h0});
      rchk(8'h09, 8'h00);
    end
  endtask
  task automatic t_irq;
    i_host.wr(8'h07, 8'h48);
    n_irq = 0;
    {tsd, bov} = 2'h3;
    w(8);
    chk(n_irq[7:0], 8'h00);
    {tsd, bov, wdog} = 3'h1;
    w(8);
    chk(n_irq[7:0], 8'h01);
    wdog = 1'h0;
    i_host.wr(8'h07, 8'h4B);
    rchk(8'h09, 8'hA8);
    n_irq = 0;
    bov = 1'h1;
    w(8);
    chk(n_irq[7:0], 8'h01);
    tsd = 1'h1;
    w(8);
    chk(n_irq[7:0], 8'h02);
    {tsd, bov} = 2'h0;
    w(4);
    rchk(8'h09, 8'h28);
  endtask
  task automatic t_unplug;
    src = 2'h2;
    w(4);
    rchk(8'h09, 8'h00);
    pres = 1'h0;
    w(6);
    rchk(8'h09, 8'h10);
    w(6);
    rchk(8'h09, 8'h00);
  endtask
  task automatic t_tick;
    therm = 1'h1;
    for (int m = 0; m < 2; m++) begin
      n_tick = 0;
      repeat (8) begin
        btk = 1'h1;
        w(1);
        btk = 1'h0;
        w(3);
      end
      w(4);
      chk(n_tick[7:0], m ? 8'h08 : 8'h04);
      i_host.wr(8'h07, 8'h0B);
      w(4);
    end
  endtask
  initial begin
    rst_n = 1'h0;
    {pres, done, wdog, bovl, blow, bsrc, tsd, tmo, bov, hbk, cbo, bmode} = 12'h000;
    {vlim, ilim, pg, therm, vsys, btk, src, ph} = 10'h000;
    w(6);
    rst_n = 1'h1;
    t_reset();
    t_ctrl();
    t_status();
    t_faults();
    t_irq();
    t_unplug();
    t_tick();
    stop_test();
  end
endmodule
`default_nettype wire
